// ---- rtl/adc_seq_defines.vh ----
// Register offsets, field positions and timing counts of the chain sequencer
`ifndef ADC_SEQ_DEFINES_VH
`define ADC_SEQ_DEFINES_VH
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_NMASK 12'h008
`define OFF_JMASK 12'h00c
`define OFF_DONE 12'h010
`define OFF_TEVT 12'h014
`define OFF_RESULT 12'h100
`define CTRL_NORMAL_CHAIN_RUNNING 0
`define CTRL_INJECTED_CHAIN_RUNNING 1
`define CTRL_SCAN 2
`define CTRL_TRIGEN 3
`define ST_NRUN 0
`define ST_JRUN 1
`define ST_TRUN 2
`define ST_NEND 3
`define ST_JEND 4
`define SAMPLE_NS 100
`define CONV_NS 200
`define SAMPLE_CYC ((`SAMPLE_NS + 19) / 20)
`define CONV_CYC ((`CONV_NS + 19) / 20)
`define NCH 32
`define RESULT_VALID 31
`endif

// ---- rtl/adc_conv_timer.v ----
// Sample and convert phase timer for one channel
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.vh"
module adc_conv_timer (
  input wire pclk,
  input wire presetn,
  input wire start,
  input wire abort,
  output reg sampling,
  output reg converting,
  output reg done
);
  localparam integer SAMP_LAST = `SAMPLE_CYC - 1;
  localparam integer CONV_LAST = `CONV_CYC - 1;
  reg [3:0] cnt_q;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 4'h0;
      sampling <= 1'b0;
      converting <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      // Restart wins over abort so a pre-empting channel always starts
      if (start) begin
        sampling <= 1'b1;
        converting <= 1'b0;
        cnt_q <= 4'h0;
      end else if (abort) begin
        sampling <= 1'b0;
        converting <= 1'b0;
      end else if (sampling) begin
        if (cnt_q == SAMP_LAST[3:0]) begin
          sampling <= 1'b0;
          converting <= 1'b1;
          cnt_q <= 4'h0;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end else if (converting) begin
        if (cnt_q == CONV_LAST[3:0]) begin
          converting <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q + 4'h1;
        end
      end
    end
  end
endmodule // adc_conv_timer
`default_nettype wire

// ---- rtl/trig_channel_latch.v ----
// Trigger unit event channel latch fed by the periodic timer
`timescale 1ns/1ps
`default_nettype none
module trig_channel_latch (
  input wire pclk,
  input wire presetn,
  input wire periodic_timer_req,
  input wire [5:0] trigger_event_config,
  output reg trig_req,
  output reg [5:0] trig_channel
);
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_req <= 1'b0;
      trig_channel <= 6'h00;
    end else begin
      trig_req <= periodic_timer_req;
      if (periodic_timer_req) begin
        trig_channel <= trigger_event_config;
      end
    end
  end
endmodule // trig_channel_latch
`default_nettype wire

// ---- rtl/adc_chain_trigger_sequencer.v ----
// Converter chain sequencer with injected and trigger-unit pre-emption
// Overview of operation
// - Injected pre-empts normal; trigger pre-empts normal and injected chains.
// - After pre-emption, aborted normal channel restored, then remaining channels in order.
// - Trigger in last channel sampling: end irq now, second after restored conversion.
// - Scan mode: trigger during last channel conversion gives no second end irq.
// - One-shot: trigger during last conversion restarts chain; irq at its end.
// - Each converted channel sets result valid bit and done flag.
// - Start flag still set at end irq means a further irq follows.
// - Single-shot mode: normal running bit falls to zero at chain end.
// - Scan mode: normal running bit stays set throughout.
// - Trigger event channel field is 6 bits, channels 0 to 63; requests for channels above 31 are dropped.
// - Periodic timer request latches the configured channel number.
//
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.vh"
module adc_chain_trigger_sequencer (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire periodic_timer_req,
  input wire [9:0] adc_sample,
  output reg [4:0] conv_channel,
  output reg conv_sampling,
  output reg normal_chain_end_irq,
  output reg injected_chain_end_irq
);
  localparam [1:0] S_IDLE = 2'd0;
  localparam [1:0] S_NORM = 2'd1;
  localparam [1:0] S_INJ = 2'd2;
  localparam [1:0] S_TRIG = 2'd3;

  reg [3:0] ctrl_q;
  reg [31:0] normal_channel_mask;
  reg [31:0] injected_channel_mask;
  reg [31:0] channel_conv_done_flags;
  reg [5:0] trigger_event_config;
  reg [31:0] channel_result_reg [0:`NCH-1];
  reg [1:0] state_q;
  reg [4:0] nptr_q;
  reg [4:0] jptr_q;
  reg normal_chain_running;
  reg injected_chain_running;
  reg nsaved_q;
  reg jsaved_q;
  reg nreq_q;
  reg jreq_q;
  reg tpend_q;
  reg start_q;
  reg tim_abort;
  reg [4:0] cur_ch;
  wire tim_s;
  wire tim_c;
  wire tim_done;
  wire trig_req;
  wire [5:0] trig_channel;
  wire wr_en;
  wire rd_en;
  integer i;

  // First enabled channel at or above a position
  function [5:0] next_ch;
    input [31:0] mask;
    input [4:0] from;
    integer k;
    reg found;
    begin
      next_ch = 6'h20;
      found = 1'b0;
      for (k = 0; k < 32; k = k + 1) begin
        if (!found && k >= from && mask[k]) begin
          next_ch = k[5:0];
          found = 1'b1;
        end
      end
    end
  endfunction

  adc_conv_timer u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_q),
    .abort(tim_abort),
    .sampling(tim_s),
    .converting(tim_c),
    .done(tim_done)
  );

  trig_channel_latch u_trig (
    .pclk(pclk),
    .presetn(presetn),
    .periodic_timer_req(periodic_timer_req & ctrl_q[`CTRL_TRIGEN]),
    .trigger_event_config(trigger_event_config),
    .trig_req(trig_req),
    .trig_channel(trig_channel)
  );

  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;

  // First and next enabled channels of each chain
  wire [5:0] n_first = next_ch(normal_channel_mask, 5'd0);
  wire [5:0] j_first = next_ch(injected_channel_mask, 5'd0);
  wire [5:0] n_next = next_ch(normal_channel_mask, nptr_q + 5'd1);
  wire [5:0] j_next = next_ch(injected_channel_mask, jptr_q + 5'd1);
  wire last_n = (n_next == 6'h20) | (nptr_q == 5'd31);
  wire last_j = (j_next == 6'h20) | (jptr_q == 5'd31);
  wire j_go = jreq_q & (state_q == S_NORM || state_q == S_IDLE);
  wire t_go = tpend_q & (state_q != S_TRIG) & ~trig_channel[5];

  always @* begin
    cur_ch = nptr_q;
    if (state_q == S_INJ)
      cur_ch = jptr_q;
    else if (state_q == S_TRIG)
      cur_ch = trig_channel[4:0];
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= 4'h0;
      normal_channel_mask <= 32'h0;
      injected_channel_mask <= 32'h0;
      channel_conv_done_flags <= 32'h0;
      trigger_event_config <= 6'h00;
      state_q <= S_IDLE;
      nptr_q <= 5'h0;
      jptr_q <= 5'h0;
      normal_chain_running <= 1'b0;
      injected_chain_running <= 1'b0;
      nsaved_q <= 1'b0;
      jsaved_q <= 1'b0;
      nreq_q <= 1'b0;
      jreq_q <= 1'b0;
      tpend_q <= 1'b0;
      start_q <= 1'b0;
      tim_abort <= 1'b0;
      normal_chain_end_irq <= 1'b0;
      injected_chain_end_irq <= 1'b0;
      conv_channel <= 5'h0;
      conv_sampling <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      for (i = 0; i < `NCH; i = i + 1)
        channel_result_reg[i] <= 32'h0;
    end else begin
      start_q <= 1'b0;
      tim_abort <= 1'b0;
      normal_chain_end_irq <= 1'b0;
      injected_chain_end_irq <= 1'b0;
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      conv_channel <= cur_ch;
      conv_sampling <= tim_s;
      // Channels above 31 are not implemented and are dropped here
      if (trig_req && !trig_channel[5])
        tpend_q <= 1'b1;
      if (rd_en) begin
        case (paddr)
          `OFF_CTRL: prdata <= {28'h0, ctrl_q};
          `OFF_STATUS: prdata <= {27'h0, tpend_q, jreq_q, state_q == S_TRIG,
                                  injected_chain_running, normal_chain_running};
          `OFF_NMASK: prdata <= normal_channel_mask;
          `OFF_JMASK: prdata <= injected_channel_mask;
          `OFF_DONE: prdata <= channel_conv_done_flags;
          `OFF_TEVT: prdata <= {26'h0, trigger_event_config};
          default: begin
            if (paddr[11:7] == 5'h02 && paddr[1:0] == 2'b00)
              prdata <= channel_result_reg[paddr[6:2]];
            else
              prdata <= 32'h0;
          end
        endcase
      end
      if (psel & ~penable) begin
        if (!(paddr <= `OFF_TEVT || paddr[11:7] == 5'h02) || paddr[1:0] != 2'b00)
          pslverr <= 1'b1;
      end
      if (wr_en && pready) begin
        case (paddr)
          `OFF_CTRL: begin
            ctrl_q <= {pwdata[3:2], 2'b00};
            if (pwdata[`CTRL_NORMAL_CHAIN_RUNNING] && normal_channel_mask != 32'h0) begin
              nreq_q <= 1'b1;
              normal_chain_running <= 1'b1;
            end
            if (pwdata[`CTRL_INJECTED_CHAIN_RUNNING] && injected_channel_mask != 32'h0) begin
              jreq_q <= 1'b1;
              injected_chain_running <= 1'b1;
            end
            if (!pwdata[`CTRL_SCAN] && !nsaved_q && state_q != S_NORM)
              normal_chain_running <= pwdata[`CTRL_NORMAL_CHAIN_RUNNING] & (normal_channel_mask != 0);
          end
          `OFF_NMASK: normal_channel_mask <= pwdata;
          `OFF_JMASK: injected_channel_mask <= pwdata;
          `OFF_DONE: channel_conv_done_flags <= channel_conv_done_flags & ~pwdata;
          `OFF_TEVT: trigger_event_config <= pwdata[5:0];
          default: ;
        endcase
      end
      // Chain scheduling
      if (t_go) begin
        tpend_q <= trig_req;
        if (state_q == S_NORM) begin
          nsaved_q <= 1'b1;
          if (last_n && tim_s)
            normal_chain_end_irq <= 1'b1;
          if (last_n && tim_c && !ctrl_q[`CTRL_SCAN])
            nptr_q <= n_first[4:0];
          if (last_n && tim_c && ctrl_q[`CTRL_SCAN])
            nsaved_q <= 1'b0;
        end
        if (state_q == S_INJ) begin
          jsaved_q <= 1'b1;
          if (last_j && tim_s)
            injected_chain_end_irq <= 1'b1;
        end
        tim_abort <= 1'b1;
        state_q <= S_TRIG;
        start_q <= 1'b1;
      end else if (j_go) begin
        jreq_q <= 1'b0;
        if (state_q == S_NORM) begin
          nsaved_q <= 1'b1;
          if (last_n && tim_s)
            normal_chain_end_irq <= 1'b1;
        end
        jptr_q <= j_first[4:0];
        tim_abort <= 1'b1;
        state_q <= S_INJ;
        start_q <= 1'b1;
      end else if (state_q == S_IDLE && (nreq_q || nsaved_q)) begin
        if (nreq_q && !nsaved_q)
          nptr_q <= n_first[4:0];
        nreq_q <= 1'b0;
        nsaved_q <= 1'b0;
        state_q <= S_NORM;
        start_q <= 1'b1;
      end else if (state_q == S_IDLE && jsaved_q) begin
        jsaved_q <= 1'b0;
        state_q <= S_INJ;
        start_q <= 1'b1;
      end else if (tim_done) begin
        channel_conv_done_flags[cur_ch] <= 1'b1;
        channel_result_reg[cur_ch] <= 32'h80000000 | {22'h0, adc_sample};
        case (state_q)
          S_TRIG: begin
            state_q <= jsaved_q ? S_INJ : (nsaved_q ? S_NORM : S_IDLE);
            start_q <= jsaved_q | nsaved_q;
            jsaved_q <= 1'b0;
            // Keep a saved normal chain while the injected one resumes
            if (!jsaved_q)
              nsaved_q <= 1'b0;
          end
          S_INJ: begin
            if (last_j) begin
              injected_chain_end_irq <= 1'b1;
              injected_chain_running <= jreq_q;
              state_q <= nsaved_q ? S_NORM : S_IDLE;
              start_q <= nsaved_q;
              nsaved_q <= 1'b0;
            end else begin
              jptr_q <= j_next[4:0];
              start_q <= 1'b1;
            end
          end
          S_NORM: begin
            if (last_n) begin
              normal_chain_end_irq <= 1'b1;
              if (ctrl_q[`CTRL_SCAN]) begin
                nptr_q <= n_first[4:0];
                start_q <= 1'b1;
              end else begin
                normal_chain_running <= nreq_q;
                state_q <= S_IDLE;
              end
            end else begin
              nptr_q <= n_next[4:0];
              start_q <= 1'b1;
            end
          end
          default: state_q <= S_IDLE;
        endcase
      end
      if (wr_en && pready && paddr == `OFF_CTRL && !pwdata[`CTRL_SCAN] && ctrl_q[`CTRL_SCAN]
          && state_q == S_NORM)
        ctrl_q[`CTRL_SCAN] <= 1'b0;
    end
  end
endmodule // adc_chain_trigger_sequencer
`default_nettype wire

// ---- tb/adc_seq_chk.sv ----
// Bus and pulse checks on the chain sequencer ports
`timescale 1ns/1ps
`default_nettype none
module adc_seq_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [4:0] conv_channel,
  input wire logic conv_sampling,
  input wire logic normal_chain_end_irq,
  input wire logic injected_chain_end_irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  setup_ready_a: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property (psel && !penable && paddr > 12'h014 && paddr < 12'h100
    |=> pslverr) else $error("unmapped access not refused");
  err_rdata_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  nirq_pulse_a: assert property (normal_chain_end_irq |=> !normal_chain_end_irq)
    else $error("normal end pulse too long");
  jirq_pulse_a: assert property ($rose(injected_chain_end_irq) |=> $fell(injected_chain_end_irq))
    else $error("injected end pulse too long");
  sample_len_a: assert property ($rose(conv_sampling) ##1 (conv_sampling && $stable(conv_channel))[*4]
    |=> !conv_sampling || $changed(conv_channel)) else $error("sampling phase too long");
  cover property (normal_chain_end_irq);
  cover property (injected_chain_end_irq);
  cover property (pready && pslverr);
endmodule // adc_seq_chk
bind adc_chain_trigger_sequencer adc_seq_chk u_adc_seq_chk (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .conv_channel(conv_channel),
  .conv_sampling(conv_sampling), .normal_chain_end_irq(normal_chain_end_irq),
  .injected_chain_end_irq(injected_chain_end_irq));
`default_nettype wire

// ---- tb/trig_source_model.sv ----
// Periodic timer request source and converter front end model
`timescale 1ns/1ps
`default_nettype none
module trig_source_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic fire,
  input wire logic [4:0] conv_channel,
  output logic periodic_timer_req,
  output logic [9:0] adc_sample
);
  // One-cycle timer request per fire pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periodic_timer_req <= 1'b0;
    end else begin
      periodic_timer_req <= fire;
    end
  end
  // Result encodes the converted channel
  assign adc_sample = {5'h14, conv_channel};
endmodule // trig_source_model
`default_nettype wire

// ---- tb/adc_chain_trigger_sequencer_test.sv ----
// Register-level test of the chain sequencer
`timescale 1ns/1ps
`default_nettype none
`include "adc_seq_defines.vh"
module adc_chain_trigger_sequencer_test;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic fire = 1'b0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, ptreq, samp, nirq, jirq;
  wire logic [9:0] sample;
  wire logic [4:0] chan;
  int n_errors = 0;
  int checks = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic err;
  always #10 pclk = ~pclk;
  adc_chain_trigger_sequencer u_adc_chain_trigger_sequencer (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .periodic_timer_req(ptreq),
    .adc_sample(sample), .conv_channel(chan), .conv_sampling(samp),
    .normal_chain_end_irq(nirq), .injected_chain_end_irq(jirq));
  trig_source_model u_trig_source_model (.pclk(pclk), .presetn(presetn), .fire(fire),
    .conv_channel(chan), .periodic_timer_req(ptreq), .adc_sample(sample));
  task print_verdict();
    if (n_errors == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task wait_irq(input logic inj);
    do @(posedge pclk); while ((inj ? jirq : nirq) !== 1'b1);
  endtask
  task shot();
    fire <= 1'b1;
    @(posedge pclk);
    fire <= 1'b0;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 6000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`OFF_STATUS, 32'h0);
    rdchk(`OFF_DONE, 32'h0);
    rdchk(12'h040, 32'h0);
    chk({31'h0, err}, 32'h1);
    // Single-shot chain over channels 0 to 2
    wr(`OFF_NMASK, 32'h7);
    wr(`OFF_CTRL, 32'h1);
    wait_irq(1'b0);
    rdchk(`OFF_STATUS, 32'h0);
    rdchk(`OFF_DONE, 32'h7);
    rdchk(`OFF_RESULT + 12'h004, 32'h80000281);
    wr(`OFF_DONE, 32'hffffffff);
    rdchk(`OFF_DONE, 32'h0);
    // Injected chain lands on the second normal channel
    wr(`OFF_NMASK, 32'hf);
    wr(`OFF_JMASK, 32'h30);
    wr(`OFF_CTRL, 32'h1);
    repeat (20) @(posedge pclk);
    wr(`OFF_CTRL, 32'h2);
    wait_irq(1'b1);
    wr(`OFF_CTRL, 32'h0);
    wait_irq(1'b0);
    rdchk(`OFF_DONE, 32'h3f);
    chk(32'hf & (32'hf ^ rd), 32'h0);
    rdchk(`OFF_RESULT + 12'h014, 32'h80000285);
    wr(`OFF_DONE, 32'hffffffff);
    // Timer request converts the configured channel
    wr(`OFF_TEVT, 32'h5);
    wr(`OFF_CTRL, 32'h8);
    shot();
    repeat (40) @(posedge pclk);
    rdchk(`OFF_DONE, 32'h20);
    wr(`OFF_DONE, 32'hffffffff);
    wr(`OFF_TEVT, 32'he5);
    rdchk(`OFF_TEVT, 32'h25);
    shot();
    repeat (40) @(posedge pclk);
    rdchk(`OFF_DONE, 32'h0);
    // Timer request lands on a running normal chain
    wr(`OFF_TEVT, 32'h9);
    wr(`OFF_NMASK, 32'h3);
    wr(`OFF_CTRL, 32'h9);
    repeat (8) @(posedge pclk);
    shot();
    wait_irq(1'b0);
    repeat (40) @(posedge pclk);
    rdchk(`OFF_DONE, 32'h203);
    rdchk(`OFF_STATUS, 32'h0);
    wr(`OFF_DONE, 32'hffffffff);
    // Scan mode keeps the running bit up
    wr(`OFF_NMASK, 32'h1);
    wr(`OFF_CTRL, 32'h5);
    wait_irq(1'b0);
    rdchk(`OFF_STATUS, 32'h1);
    wr(`OFF_CTRL, 32'h0);
    wait_irq(1'b0);
    rdchk(`OFF_STATUS, 32'h0);
    print_verdict();
  end
endmodule // adc_chain_trigger_sequencer_test
`default_nettype wire
